/* rcg_consts.vh */
`ifndef RCG_CONSTS_VH
`define RCG_CONSTS_VH
// register byte offsets
`define RCG_OFF_CTRL 8'h00
`define RCG_OFF_TRIG 8'h04
`define RCG_OFF_PINCFG 8'h08
`define RCG_OFF_BASE 8'h0C
`define RCG_OFF_DEV 8'h10
`define RCG_OFF_LIMLO 8'h14
`define RCG_OFF_LIMHI 8'h18
`define RCG_OFF_COMPARATOR_ZERO_FLAG 8'h1C
`define RCG_OFF_COMPARATOR_ONE_FLAG 8'h20
`define RCG_OFF_MSB 8'h24
`define RCG_OFF_CMPMASK 8'h28
`define RCG_OFF_STATUS 8'h2C
`define RCG_OFF_MASK 8'h30
`define RCG_OFF_VALUE 8'h34
`define RCG_OFF_STATE 8'h38
`define RCG_OFF_SEG 8'h40
// control fields
`define RCG_CTRL_EN 0
`define RCG_CTRL_COMPARATOR_ZERO_FLAG 1
`define RCG_CTRL_COMPARATOR_ONE_FLAG 2
`define RCG_CTRL_FSK_LO 4
// trigger select fields, pin index 0..2
`define RCG_TRIGA_LO 0
`define RCG_TRIGB_LO 4
// segment config word fields
`define RCG_SEG_DLY 16
`define RCG_SEG_RST 17
`define RCG_SEG_NEXT_LO 18
`define RCG_SEG_SRC_LO 21
// pin functions
`define RCG_PIN_LOW 3'h0
`define RCG_PIN_COMPARATOR_ZERO_FLAG 3'h1
`define RCG_PIN_COMPARATOR_ONE_FLAG 3'h2
`define RCG_PIN_START 3'h3
`define RCG_PIN_INPUT 3'h7
// advance sources
`define RCG_SRC_TIMEOUT 2'h0
`define RCG_SRC_TRIGA 2'h1
`define RCG_SRC_TRIGB 2'h2
`define RCG_SRC_EITHER 2'h3
// status bits
`define RCG_ST_COMPARATOR_ZERO_FLAG 0
`define RCG_ST_COMPARATOR_ONE_FLAG 1
`define RCG_ST_START 2
`define RCG_ST_TRIG 3
// reset values
`define RCG_RST_PINCFG 32'h0000_0777
`define RCG_RST_LIMLO 33'h1_FF00_0000
`define RCG_RST_LIMHI 33'h0_00FF_FFFF
`endif

/* rcg_pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module rcg_pin_partner (
    input wire logic clk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] trig,
    output logic [2:0] pin_in,
    output logic [15:0] start_edges
);
    logic [2:0] drv_q;
    logic prev_q;
    // sources drive only released pins, else the wire follows the block
    assign pin_in = (pin_oe & drv_q) | (~pin_oe & pin_out);
    initial start_edges = 16'h0;
    // trigger levels change on clock edges; count rising start flags on pin zero
    always @(posedge clk) begin
        drv_q <= trig;
        prev_q <= pin_out[0];
        if (!pin_oe[0] && pin_out[0] && !prev_q) start_edges <= start_edges + 16'h1;
    end
endmodule // rcg_pin_partner
`default_nettype wire

/* rcg_ramp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcg_consts.vh"
module rcg_ramp_chk #(
    parameter NSEG = 8,
    parameter NPIN = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    input wire logic [NPIN-1:0] pin_in,
    input wire logic [NPIN-1:0] pin_out,
    input wire logic [NPIN-1:0] pin_oe,
    input wire logic [32:0] numerator,
    input wire logic ramp_active
);
    logic [31:0] cfg_q;
    logic [2:0] ctrl_q;
    logic [3:0] mask_q;
    logic ctrl_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign ctrl_wr = reg_wr && reg_addr == `RCG_OFF_CTRL;
    // shadow of fields the pins and the interrupt hang on; the block body stays opaque
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= `RCG_RST_PINCFG;
            ctrl_q <= 3'h0;
            mask_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == `RCG_OFF_PINCFG) cfg_q <= reg_wdata;
            if (ctrl_wr) ctrl_q <= reg_wdata[2:0];
            if (reg_wr && reg_addr == `RCG_OFF_MASK) mask_q <= reg_wdata[3:0];
        end
    end
    ////////////////////////////////////////
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_enable_starts: assert property (ctrl_wr && reg_wdata[0] && !ctrl_q[0] |-> ##[1:3] ramp_active)
        else $error("enable did not start the sequencer");
    a_start_flag_out: assert property (ctrl_wr && reg_wdata[0] && !ctrl_q[0] &&
        cfg_q[2:0] == `RCG_PIN_START |-> ##[1:3] pin_out[0])
        else $error("no segment start flag after enable");
    a_disable_stops: assert property (ctrl_wr && !reg_wdata[0] |-> ##[1:4] !ramp_active)
        else $error("disable did not stop the sequencer");
    a_idle_holds_value: assert property (!ramp_active && !$past(ramp_active) && !$past(reg_wr) &&
        !$past(reg_wr, 2) |-> $stable(numerator))
        else $error("numerator moved while idle");
    a_rise_needs_enable: assert property ($rose(ramp_active) |-> ctrl_q[0] && $past(ctrl_q[0], 2))
        else $error("sequencer ran without enable");
    a_oe_matches_cfg: assert property (pin_oe == {cfg_q[10:8] == `RCG_PIN_INPUT,
        cfg_q[6:4] == `RCG_PIN_INPUT, cfg_q[2:0] == `RCG_PIN_INPUT})
        else $error("pin direction differs from pin function");
    a_low_pin_quiet: assert property (cfg_q[2:0] == `RCG_PIN_LOW |-> !pin_out[0])
        else $error("low pin driven high");
    a_cmp_off_quiet: assert property (!ctrl_q[1] && !$past(ctrl_q[1]) &&
        cfg_q[6:4] == `RCG_PIN_COMPARATOR_ZERO_FLAG |-> !pin_out[1])
        else $error("disabled comparator flag high");
    a_irq_masked_off: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
        else $error("interrupt with all sources masked");
endmodule // rcg_ramp_chk
bind rcg_ramp_gen rcg_ramp_chk #(.NSEG(NSEG), .NPIN(NPIN)) u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .numerator(numerator), .ramp_active(ramp_active));
`default_nettype wire

/* rcg_ramp_gen.v */
// Functional notes
// RULE1 - segment succeeding itself repeats forever
// RULE2 - keying deviation added onto momentary ramp value
// RULE3 - master enable starts ramp and keying together
// RULE4 - no reset: continue from previous numerator
// RULE5 - comparator flags routable to multipurpose pins
// RULE6 - comparator segment mask, one bit per segment
// RULE7 - step count reaches 65536 steps per segment
// RULE8 - step delay: increment every second cycle
// RULE9 - eight segments chainable in any order
// RULE10 - segment start flag on multipurpose pin
// RULE11 - external edge on input pin triggers ramp
// RULE12 - increment added once per detector cycle
// RULE13 - advance source: 0 timeout, 2 trigger B
// RULE14 - limits are 33-bit two's complement offsets
// RULE15 - deviation scales detector rate by 2^-24
// RULE16 - enable starts segment 0; disable returns
//
// The implementer's own choices: the strobed register port, the placing of the registers and advance source 3.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_consts.vh"

module rcg_ramp_gen #(
    parameter NSEG = 8,
    parameter NPIN = 3
) (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output wire irq,
    input wire [NPIN-1:0] pin_in,
    output reg [NPIN-1:0] pin_out,
    output reg [NPIN-1:0] pin_oe,
    output reg [32:0] numerator,
    output reg ramp_active
);

////////////////////////////////////////////////////////////////////////////////
// configuration registers
reg [31:0] ctrl_q;
reg [31:0] trig_q;
reg [31:0] pincfg_q;
reg [31:0] base_q;
reg [31:0] dev_q;
reg [32:0] lim_lo_q;
reg [32:0] lim_hi_q;
reg [32:0] comparator_zero_flag_q;
reg [32:0] comparator_one_flag_q;
reg [15:0] cmpmask_q;
reg [3:0] status_q;
reg [3:0] mask_q;
reg [31:0] seg_inc_q [0:NSEG-1];
reg [31:0] seg_cfg_q [0:NSEG-1];

// sequencer state
localparam ST_IDLE = 2'h0;
localparam ST_RUN = 2'h1;
localparam ST_WAIT = 2'h2;
reg [1:0] st_q;
reg [2:0] seg_q;
reg [15:0] cnt_q;
reg half_q;
reg en_prev_q;
reg [32:0] acc_q;
reg fsk_on_q;
reg start_q;
reg comparator_zero_flag_flag_q;
reg comparator_one_flag_flag_q;
reg [NPIN-1:0] pin_prev_q;

////////////////////////////////////////////////////////////////////////////////
// trigger decode from input pins
wire ramp_en = ctrl_q[`RCG_CTRL_EN];
wire [1:0] trga_sel = trig_q[`RCG_TRIGA_LO +: 2];
wire [1:0] trgb_sel = trig_q[`RCG_TRIGB_LO +: 2];
wire [NPIN-1:0] pin_rise;
genvar gi;
generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
        // only a pin set as input may trigger [RULE11]
        assign pin_rise[gi] = (pincfg_q[4*gi +: 3] == `RCG_PIN_INPUT) && pin_in[gi] && !pin_prev_q[gi];
        // output function mux; pins idle low when not input
        always @* begin
            pin_oe[gi] = 1'b0;
            case (pincfg_q[4*gi +: 3])
                `RCG_PIN_COMPARATOR_ZERO_FLAG: pin_out[gi] = comparator_zero_flag_flag_q; // [RULE5]
                `RCG_PIN_COMPARATOR_ONE_FLAG: pin_out[gi] = comparator_one_flag_flag_q; // [RULE5]
                `RCG_PIN_START: pin_out[gi] = start_q; // [RULE10]
                `RCG_PIN_INPUT: begin
                    pin_out[gi] = 1'b0;
                    pin_oe[gi] = 1'b1;
                end
                default: pin_out[gi] = 1'b0;
            endcase
        end
    end
endgenerate
wire trig_a = (trga_sel < NPIN) && pin_rise[trga_sel]; // [RULE11]
wire trig_b = (trgb_sel < NPIN) && pin_rise[trgb_sel];

////////////////////////////////////////////////////////////////////////////////
// current segment fields
wire [31:0] cur_cfg = seg_cfg_q[seg_q];
wire [2:0] cur_next = cur_cfg[`RCG_SEG_NEXT_LO +: 3];
wire [1:0] cur_src = cur_cfg[`RCG_SEG_SRC_LO +: 2];
wire cur_dly = cur_cfg[`RCG_SEG_DLY];
wire [31:0] nxt_cfg = seg_cfg_q[cur_next];
wire [15:0] nxt_len = nxt_cfg[15:0];
wire [15:0] seg0_len = seg_cfg_q[0][15:0];

// source 3 is our extension: either trigger advances [RULE13]
reg src_ok;
always @* begin
    case (cur_src)
        `RCG_SRC_TIMEOUT: src_ok = 1'b1;
        `RCG_SRC_TRIGA: src_ok = trig_a;
        `RCG_SRC_TRIGB: src_ok = trig_b;
        default: src_ok = trig_a | trig_b;
    endcase
end

// step cadence: every cycle, or every second one [RULE12] [RULE8]
wire step_now = (st_q == ST_RUN) && (!cur_dly || half_q);
wire timeout = step_now && (cnt_q == 16'h0000);
// a trigger source is only honoured after the timeout
wire go_next = (timeout && cur_src == `RCG_SRC_TIMEOUT) || ((st_q == ST_WAIT) && src_ok);

// next ramp value, clamped to the 33-bit limits [RULE14]
wire signed [33:0] sum = {acc_q[32], acc_q} + {{2{seg_inc_q[seg_q][31]}}, seg_inc_q[seg_q]};
wire signed [33:0] lo_ext = {lim_lo_q[32], lim_lo_q};
wire signed [33:0] hi_ext = {lim_hi_q[32], lim_hi_q};
reg [32:0] acc_step;
always @* begin
    if (sum < lo_ext) begin
        acc_step = lim_lo_q;
    end else if (sum > hi_ext) begin
        acc_step = lim_hi_q;
    end else begin
        acc_step = sum[32:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// keying trigger selection
wire [1:0] fsk_src = ctrl_q[`RCG_CTRL_FSK_LO +: 2];
wire fsk_evt = (fsk_src == 2'h1 && trig_a) || (fsk_src == 2'h2 && trig_b);

// sequencer
always @(posedge clk) begin
    if (rst) begin
        st_q <= ST_IDLE;
        seg_q <= 3'h0;
        cnt_q <= 16'h0000;
        half_q <= 1'b0;
        en_prev_q <= 1'b0;
        acc_q <= 33'h0;
        fsk_on_q <= 1'b0;
        start_q <= 1'b0;
        pin_prev_q <= {NPIN{1'b0}};
    end else begin
        start_q <= 1'b0;
        en_prev_q <= ramp_en;
        pin_prev_q <= pin_in;
        if (!ramp_en) begin
            // back to the unmodulated numerator [RULE16]
            st_q <= ST_IDLE;
            acc_q <= 33'h0;
            fsk_on_q <= 1'b0;
        end else if (!en_prev_q) begin
            // one enable wakes ramp and keying [RULE3] [RULE16]
            st_q <= ST_RUN;
            seg_q <= 3'h0;
            cnt_q <= seg0_len - 16'h0001; // 0 wraps to 65535: 65536 steps [RULE7]
            half_q <= 1'b0;
            acc_q <= 33'h0;
            fsk_on_q <= 1'b0;
            start_q <= 1'b1;
        end else begin
            if (fsk_evt) begin
                fsk_on_q <= !fsk_on_q;
            end
            if (st_q == ST_RUN) begin
                half_q <= cur_dly ? !half_q : 1'b0; // [RULE8]
                if (step_now) begin
                    acc_q <= acc_step; // [RULE12]
                    cnt_q <= cnt_q - 16'h0001;
                    if (timeout) begin
                        st_q <= ST_WAIT;
                    end
                end
            end
            if (go_next) begin
                // successor may be any segment, itself included [RULE1] [RULE9]
                st_q <= ST_RUN;
                seg_q <= cur_next;
                cnt_q <= nxt_len - 16'h0001; // [RULE7]
                half_q <= 1'b0;
                start_q <= 1'b1; // [RULE10]
                // without reset the value carries over [RULE4]
                if (nxt_cfg[`RCG_SEG_RST]) begin
                    acc_q <= 33'h0;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// comparators gated by per-segment mask [RULE6]
wire run_any = (st_q != ST_IDLE);
wire comparator_zero_flag_hit = ctrl_q[`RCG_CTRL_COMPARATOR_ZERO_FLAG] && run_any && cmpmask_q[seg_q] &&
    ($signed(acc_q) >= $signed(comparator_zero_flag_q));
wire comparator_one_flag_hit = ctrl_q[`RCG_CTRL_COMPARATOR_ONE_FLAG] && run_any && cmpmask_q[8 + seg_q] &&
    ($signed(acc_q) >= $signed(comparator_one_flag_q));

// deviation in units of f_pd / 2^24, signed 24-bit [RULE15]
wire [32:0] dev_ext = {{9{dev_q[23]}}, dev_q[23:0]};

// output numerator and flags
always @(posedge clk) begin
    if (rst) begin
        numerator <= 33'h0;
        ramp_active <= 1'b0;
        comparator_zero_flag_flag_q <= 1'b0;
        comparator_one_flag_flag_q <= 1'b0;
    end else begin
        // keying rides on the momentary ramp value [RULE2]
        numerator <= {1'b0, base_q} + acc_q + (fsk_on_q ? dev_ext : 33'h0);
        ramp_active <= run_any;
        comparator_zero_flag_flag_q <= comparator_zero_flag_hit; // [RULE5]
        comparator_one_flag_flag_q <= comparator_one_flag_hit; // [RULE5]
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt events; a set beats a read-clear in the same cycle
wire [3:0] evt = {trig_a | trig_b, start_q, comparator_one_flag_hit & !comparator_one_flag_flag_q, comparator_zero_flag_hit & !comparator_zero_flag_flag_q};
wire st_rd = reg_rd && (reg_addr == `RCG_OFF_STATUS);
assign irq = |(status_q & mask_q);

// register writes
integer i;
always @(posedge clk) begin
    if (rst) begin
        ctrl_q <= 32'h0;
        trig_q <= 32'h0;
        pincfg_q <= `RCG_RST_PINCFG;
        base_q <= 32'h0;
        dev_q <= 32'h0;
        lim_lo_q <= `RCG_RST_LIMLO;
        lim_hi_q <= `RCG_RST_LIMHI;
        comparator_zero_flag_q <= 33'h0;
        comparator_one_flag_q <= 33'h0;
        cmpmask_q <= 16'h0000;
        status_q <= 4'h0;
        mask_q <= 4'h0;
        for (i = 0; i < NSEG; i = i + 1) begin
            seg_inc_q[i] <= 32'h0;
            seg_cfg_q[i] <= 32'h0;
        end
    end else begin
        status_q <= (st_rd ? 4'h0 : status_q) | evt;
        if (reg_wr) begin
            if (reg_addr == `RCG_OFF_CTRL) begin
                ctrl_q <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_TRIG) begin
                trig_q <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_PINCFG) begin
                pincfg_q <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_BASE) begin
                base_q <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_DEV) begin
                dev_q <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_LIMLO) begin
                lim_lo_q[31:0] <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_LIMHI) begin
                lim_hi_q[31:0] <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_COMPARATOR_ZERO_FLAG) begin
                comparator_zero_flag_q[31:0] <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_COMPARATOR_ONE_FLAG) begin
                comparator_one_flag_q[31:0] <= reg_wdata;
            end else if (reg_addr == `RCG_OFF_MSB) begin
                // bit 32 of each 33-bit threshold [RULE14]
                lim_lo_q[32] <= reg_wdata[0];
                lim_hi_q[32] <= reg_wdata[1];
                comparator_zero_flag_q[32] <= reg_wdata[2];
                comparator_one_flag_q[32] <= reg_wdata[3];
            end else if (reg_addr == `RCG_OFF_CMPMASK) begin
                cmpmask_q <= reg_wdata[15:0]; // [RULE6]
            end else if (reg_addr == `RCG_OFF_MASK) begin
                mask_q <= reg_wdata[3:0];
            end else if (reg_addr >= `RCG_OFF_SEG && reg_addr < `RCG_OFF_SEG + 8'h40) begin
                // segment n: increment at 0x40+8n, config at 0x44+8n [RULE9]
                if (reg_addr[2]) begin
                    seg_cfg_q[reg_addr[5:3]] <= reg_wdata;
                end else begin
                    seg_inc_q[reg_addr[5:3]] <= reg_wdata;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data, one cycle after the strobe; unmapped reads zero
always @(posedge clk) begin
    if (rst) begin
        reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
        reg_rdata <= 32'h0;
    end else if (reg_addr == `RCG_OFF_CTRL) begin
        reg_rdata <= ctrl_q;
    end else if (reg_addr == `RCG_OFF_TRIG) begin
        reg_rdata <= trig_q;
    end else if (reg_addr == `RCG_OFF_PINCFG) begin
        reg_rdata <= pincfg_q;
    end else if (reg_addr == `RCG_OFF_BASE) begin
        reg_rdata <= base_q;
    end else if (reg_addr == `RCG_OFF_DEV) begin
        reg_rdata <= dev_q;
    end else if (reg_addr == `RCG_OFF_LIMLO) begin
        reg_rdata <= lim_lo_q[31:0];
    end else if (reg_addr == `RCG_OFF_LIMHI) begin
        reg_rdata <= lim_hi_q[31:0];
    end else if (reg_addr == `RCG_OFF_COMPARATOR_ZERO_FLAG) begin
        reg_rdata <= comparator_zero_flag_q[31:0];
    end else if (reg_addr == `RCG_OFF_COMPARATOR_ONE_FLAG) begin
        reg_rdata <= comparator_one_flag_q[31:0];
    end else if (reg_addr == `RCG_OFF_MSB) begin
        reg_rdata <= {28'h0, comparator_one_flag_q[32], comparator_zero_flag_q[32], lim_hi_q[32], lim_lo_q[32]};
    end else if (reg_addr == `RCG_OFF_CMPMASK) begin
        reg_rdata <= {16'h0, cmpmask_q};
    end else if (reg_addr == `RCG_OFF_STATUS) begin
        reg_rdata <= {28'h0, status_q};
    end else if (reg_addr == `RCG_OFF_MASK) begin
        reg_rdata <= {28'h0, mask_q};
    end else if (reg_addr == `RCG_OFF_VALUE) begin
        reg_rdata <= acc_q[31:0];
    end else if (reg_addr == `RCG_OFF_STATE) begin
        reg_rdata <= {acc_q[32], 22'h0, fsk_on_q, 1'b0, seg_q, st_q, comparator_one_flag_flag_q, comparator_zero_flag_flag_q};
    end else if (reg_addr >= `RCG_OFF_SEG && reg_addr < `RCG_OFF_SEG + 8'h40) begin
        reg_rdata <= reg_addr[2] ? seg_cfg_q[reg_addr[5:3]] : seg_inc_q[reg_addr[5:3]];
    end else begin
        reg_rdata <= 32'h0;
    end
end

endmodule // rcg_ramp_gen
`default_nettype wire

/* rcg_ramp_gen_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rcg_consts.vh"
module rcg_ramp_gen_tb_top;
    logic clk, rst, reg_wr, reg_rd, irq, ramp_active, rd_q;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, base, inc, b;
    logic [2:0] pin_in, pin_out, pin_oe, trig;
    logic [32:0] numerator, n0;
    logic [15:0] start_edges, e0;
    logic [31:0] exp_q[$];
    integer seed, mismatches, checks, i, k;

    rcg_ramp_gen #(.NSEG(8), .NPIN(3)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .numerator(numerator), .ramp_active(ramp_active));
    rcg_pin_partner partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .trig(trig), .pin_in(pin_in),
        .start_edges(start_edges));

    // 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] s);
        checks = checks + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("FAIL read data expected %h seen %h", e, s);
        end
    endtask
    task automatic cmp_val(input string nm, input logic [32:0] e, input logic [32:0] s);
        checks = checks + 1;
        if (s !== e) begin
            mismatches = mismatches + 1;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic seg(input logic [2:0] n, input logic [31:0] v, input logic [15:0] len, input logic dly,
        input logic clr, input logic [2:0] nxt, input logic [1:0] src);
        wr(`RCG_OFF_SEG + {2'h0, n, 3'h0}, v);
        wr(`RCG_OFF_SEG + {2'h0, n, 3'h4}, {9'h0, src, nxt, clr, dly, len});
    endtask
    // bounded wait for a numerator value; a miss ends the run
    task automatic wait_num(input logic [31:0] e);
        for (k = 0; k < 200 && numerator !== {1'b0, e}; k++) @(posedge clk);
        cmp_val("numerator", {1'b0, e}, numerator);
        if (numerator !== {1'b0, e}) results();
    endtask
    // read data land one cycle after the strobe; oldest note is matched
    always @(posedge clk) begin
        if (rd_q) cmp_rd(exp_q.pop_front(), reg_rdata);
        rd_q <= reg_rd;
    end
    ////////////////////////////////////////
    initial begin
        seed = 41576;
        mismatches = 0;
        checks = 0;
        {rst, reg_wr, reg_rd, rd_q} = 4'h8;
        {reg_addr, reg_wdata, trig} = 43'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`RCG_OFF_PINCFG, `RCG_RST_PINCFG);
        rd(`RCG_OFF_LIMLO, 32'hFF00_0000);
        rd(`RCG_OFF_LIMHI, 32'h00FF_FFFF);
        rd(8'h3C, 32'h0);
        base = ($random(seed) & 32'h0FFF_FFFF) | 32'h0100_0000;
        inc = ($random(seed) & 32'hFF) + 32'h1;
        b = ($random(seed) & 32'hFF) + 32'h1;
        // self-looping segment with a comparator that first ignores it
        wr(`RCG_OFF_BASE, base);
        wait_num(base);
        wr(`RCG_OFF_PINCFG, 32'h0000_0013);
        wr(`RCG_OFF_MSB, 32'h1);
        wr(`RCG_OFF_COMPARATOR_ZERO_FLAG, inc * 8);
        wr(`RCG_OFF_CMPMASK, 32'h2);
        seg(3'h0, inc, 16'h4, 1'b0, 1'b0, 3'h0, `RCG_SRC_TIMEOUT);
        wr(`RCG_OFF_CTRL, 32'h3);
        wait_num(base + inc);
        for (i = 0; i < 10; i++) begin
            n0 = numerator;
            @(posedge clk);
            cmp_val("ramp step", n0 + {1'b0, inc}, numerator);
        end
        e0 = start_edges;
        repeat (16) @(posedge clk);
        cmp_val("start flags", 33'h4, {17'h0, start_edges - e0});
        cmp_val("comparator_zero_flag pin", 33'h0, {32'h0, pin_out[1]});
        wr(`RCG_OFF_CMPMASK, 32'h3);
        for (k = 0; k < 8 && pin_out[1] !== 1'b1; k++) @(posedge clk);
        cmp_val("comparator_zero_flag pin", 33'h1, {32'h0, pin_out[1]});
        rd(`RCG_OFF_STATUS, 32'h5);
        wr(`RCG_OFF_CTRL, 32'h0);
        wait_num(base);
        // stepping every second cycle
        seg(3'h0, inc, 16'h8, 1'b1, 1'b0, 3'h0, `RCG_SRC_TIMEOUT);
        wr(`RCG_OFF_CTRL, 32'h1);
        wait_num(base + inc);
        n0 = numerator;
        repeat (8) @(posedge clk);
        cmp_val("delayed ramp", n0 + {1'b0, inc * 4}, numerator);
        wr(`RCG_OFF_CTRL, 32'h0);
        wait_num(base);
        // chain 0 to 5, wait on trigger B, keying toggled by the same edge
        wr(`RCG_OFF_DEV, 32'h00FF_FFF0);
        wr(`RCG_OFF_PINCFG, 32'h0000_0713);
        wr(`RCG_OFF_TRIG, 32'h0000_0023);
        wr(`RCG_OFF_MASK, 32'h8);
        seg(3'h0, inc, 16'h3, 1'b0, 1'b1, 3'h5, `RCG_SRC_TIMEOUT);
        seg(3'h5, b, 16'h2, 1'b0, 1'b0, 3'h0, `RCG_SRC_TRIGB);
        wr(`RCG_OFF_CTRL, 32'h21);
        wait_num(base + inc * 3 + b * 2);
        repeat (10) @(posedge clk);
        cmp_val("waiting", {1'b0, base + inc * 3 + b * 2}, numerator);
        cmp_val("irq", 33'h0, {32'h0, irq});
        rd(`RCG_OFF_STATUS, 32'h4);
        trig <= 3'h4;
        wait_num(base + inc - 32'h10);
        wait_num(base + inc * 3 + b * 2 - 32'h10);
        trig <= 3'h0;
        cmp_val("irq", 33'h1, {32'h0, irq});
        rd(`RCG_OFF_STATUS, 32'hC);
        // the clear lands on the strobe's edge; let it settle first
        @(posedge clk);
        cmp_val("irq", 33'h0, {32'h0, irq});
        wr(`RCG_OFF_CTRL, 32'h0);
        wait_num(base);
        repeat (3) @(posedge clk);
        results();
    end
endmodule // rcg_ramp_gen_tb_top
`default_nettype wire
